// ---- hw/csi_core.sv ----
// Behaviour
// RULE1: accesses to 00H and 02H go to RAM at pointer a or pointer b.
// RULE2: indirect access whose pointer selects 00H or 02H reads zero, writes nothing.
// RULE3: both pointers are 8 bits; only pointer b reaches display memory.
// RULE4: accumulator sits at 05H; no direct indirect-to-indirect move exists.
// RULE5: ALU does add, subtract, decimal adjust, logic, rotate, inc, dec, skips.
// RULE6: status register at 0AH holds carry, half carry, zero, overflow, halt, watchdog.
// RULE7: software writes to status leave halt and watchdog flags untouched.
// RULE8: bit 0 is carry or no-borrow; rotate through carry loads it.
// RULE9: bit 1 is low nibble carry or no-borrow into low nibble.
// RULE10: bit 2 set when an arithmetic or logic result is zero.
// RULE11: bit 3 set when carry into MSB differs from carry out.
// RULE12: bit 4 cleared by reset or watchdog clear, set by halt.
// RULE13: bit 5 cleared by reset, watchdog clear or halt; set by timeout.
// RULE14: status bits 6 and 7 read as zero.
// RULE15: calls and interrupt entries never save the status register.
// RULE16: interrupt acknowledge pushes the program counter and jumps to vector.
// RULE17: acknowledge clears global enable; later requests only latch flags.
// RULE18: handler re-enabling global and source enable allows nested service.
// RULE19: no acknowledge while stack is full; request stays pending.
// RULE20: falling edge on external pin a or b sets bit 4 or 5.
// RULE21: external service calls 04H or 08H, clearing its flag and enable; the code clears the flag and global enable, the source enable stays set.
// RULE22: any interrupt request wakes the device from halt.
// RULE23: general RAM lives at 20H to FFH, direct and through pointers.
// RULE24: bit 0 of control register a is the global interrupt enable.
// RULE25: priority: ext a, ext b, timer 0, timer 1, time base, clock.
// RULE26: internal overflow pulses set sticky flags until serviced or cleared.
// RULE27: simultaneous requests: highest served at boundary, others stay latched.
`timescale 1ns/100ps
module csi_core (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [7:0] DM_ADDR_I,
    input wire logic DM_RD_I,
    input wire logic DM_WR_I,
    input wire logic [7:0] DM_WDATA_I,
    output logic [7:0] DM_RDATA_O,
    input wire logic ALU_GO_I,
    input wire logic [4:0] ALU_OP_I,
    input wire logic ALU_DEST_ACC_I,
    output logic SKIP_O,
    input wire logic DISP_BANK_I,
    input wire logic [7:0] DISP_RDATA_I,
    output logic [7:0] DISP_ADDR_O,
    output logic [7:0] DISP_WDATA_O,
    output logic DISP_WE_O,
    input wire logic HALT_EXEC_I,
    input wire logic WDT_CLEAR_I,
    input wire logic WDT_TIMEOUT_I,
    output logic HALTED_O,
    input wire logic EXT_IRQ_A_N_I,
    input wire logic EXT_IRQ_B_N_I,
    input wire logic TMR0_OVF_I,
    input wire logic TMR1_OVF_I,
    input wire logic TBASE_I,
    input wire logic RTC_I,
    input wire logic BOUNDARY_I,
    input wire logic STACK_FULL_I,
    input wire logic RETI_I,
    output logic IRQ_CALL_O,
    output logic [12:0] IRQ_VECTOR_O
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ram_q [csi_pkg::RAM_DEPTH];
    logic [7:0] ram_pointer_a_q, ram_pointer_a_d;
    logic [7:0] ram_pointer_b_q, ram_pointer_b_d;
    logic [7:0] acc_q, acc_d;
    csi_pkg::csi_status_type st_q, st_d;
    logic global_irq_enable_q, global_irq_enable_d;
    logic [5:0] irq_en_q, irq_en_d;
    logic [5:0] irq_req_q, irq_req_d;
    logic [7:0] rdata_q, rdata_d;
    logic skip_q, skip_d;
    logic halted_q, halted_d;
    logic call_q, call_d;
    logic [12:0] vec_q, vec_d;
    logic [7:0] disp_wdata_q, disp_wdata_d;
    logic disp_we_q, disp_we_d;
    logic [2:0] ext_a_sync_q, ext_b_sync_q;
    logic ram_we;
    logic [7:0] ram_wa, ram_wd;

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    function automatic logic is_ind(input logic [7:0] a);
        return (a == csi_pkg::ADDR_IND_A) || (a == csi_pkg::ADDR_IND_B);
    endfunction

    function automatic logic [7:0] eff_addr(input logic [7:0] a);
        if (a == csi_pkg::ADDR_IND_A) begin
            return ram_pointer_a_q; // [RULE1]
        end
        if (a == csi_pkg::ADDR_IND_B) begin
            return ram_pointer_b_q; // [RULE1]
        end
        return a;
    endfunction

    function automatic logic [7:0] rd_value(input logic [7:0] a);
        logic [7:0] e;
        e = eff_addr(a);
        if (is_ind(a) && is_ind(e)) begin
            return csi_pkg::RST_BYTE; // [RULE2]
        end
        if (a == csi_pkg::ADDR_IND_B && DISP_BANK_I) begin
            return DISP_RDATA_I; // [RULE3]
        end
        if (e >= csi_pkg::ADDR_RAM_LO) begin
            return ram_q[e - csi_pkg::ADDR_RAM_LO]; // [RULE23]
        end
        case (e)
            csi_pkg::ADDR_PTR_A: return ram_pointer_a_q;
            csi_pkg::ADDR_PTR_B: return ram_pointer_b_q;
            csi_pkg::ADDR_ACC: return acc_q; // [RULE4]
            csi_pkg::ADDR_FLAGS: return {2'b00, st_q}; // [RULE6] [RULE14]
            csi_pkg::ADDR_IRQ_CTRL_A:
                return {1'b0, irq_req_q[2:0], irq_en_q[2:0],
                        global_irq_enable_q};
            csi_pkg::ADDR_IRQ_CTRL_B:
                return {1'b0, irq_req_q[5:3], 1'b0, irq_en_q[5:3]};
            default: return csi_pkg::RST_BYTE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // arithmetic unit
    // ------------------------------------------------------------
    logic [7:0] opnd, bb, alu_res;
    logic [8:0] sum9;
    logic [4:0] low5;
    logic cin, alu_writes, is_arith, is_logic, is_skip;
    csi_pkg::csi_alu_op_type op;

    always_comb begin
        op = csi_pkg::csi_alu_op_type'(ALU_OP_I);
        opnd = rd_value(DM_ADDR_I);
        bb = (op == csi_pkg::OP_SUB || op == csi_pkg::OP_SBC) ? ~opnd : opnd;
        case (op)
            csi_pkg::OP_ADC, csi_pkg::OP_SBC: cin = st_q.carry_flag;
            csi_pkg::OP_SUB: cin = 1'b1;
            default: cin = 1'b0;
        endcase
        sum9 = {1'b0, acc_q} + {1'b0, bb} + {8'h00, cin};
        low5 = {1'b0, acc_q[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        is_arith = (op == csi_pkg::OP_ADD) || (op == csi_pkg::OP_ADC) ||
                   (op == csi_pkg::OP_SUB) || (op == csi_pkg::OP_SBC);
        is_logic = (op == csi_pkg::OP_AND) || (op == csi_pkg::OP_OR) ||
                   (op == csi_pkg::OP_XOR) || (op == csi_pkg::OP_CPL) ||
                   (op == csi_pkg::OP_INC) || (op == csi_pkg::OP_DEC);
        is_skip = (op == csi_pkg::OP_SZ) || (op == csi_pkg::OP_SNZ) ||
                  (op == csi_pkg::OP_SIZ) || (op == csi_pkg::OP_SDZ);
        alu_writes = (op != csi_pkg::OP_SZ) && (op != csi_pkg::OP_SNZ);
        case (op) // [RULE5]
            csi_pkg::OP_ADD, csi_pkg::OP_ADC,
            csi_pkg::OP_SUB, csi_pkg::OP_SBC: alu_res = sum9[7:0];
            csi_pkg::OP_DAA: alu_res = acc_q +
                (((acc_q[3:0] > csi_pkg::BCD_LIMIT) || st_q.half_carry_flag)
                    ? csi_pkg::BCD_ADJ_LO : 8'h00) +
                (((acc_q[7:4] > csi_pkg::BCD_LIMIT) || st_q.carry_flag)
                    ? csi_pkg::BCD_ADJ_HI : 8'h00);
            csi_pkg::OP_AND: alu_res = acc_q & opnd;
            csi_pkg::OP_OR: alu_res = acc_q | opnd;
            csi_pkg::OP_XOR: alu_res = acc_q ^ opnd;
            csi_pkg::OP_CPL: alu_res = ~opnd;
            csi_pkg::OP_RL: alu_res = {opnd[6:0], opnd[7]};
            csi_pkg::OP_RR: alu_res = {opnd[0], opnd[7:1]};
            csi_pkg::OP_RLC: alu_res = {opnd[6:0], st_q.carry_flag};
            csi_pkg::OP_RRC: alu_res = {st_q.carry_flag, opnd[7:1]};
            csi_pkg::OP_INC, csi_pkg::OP_SIZ: alu_res = opnd + 8'h01;
            csi_pkg::OP_DEC, csi_pkg::OP_SDZ: alu_res = opnd - 8'h01;
            default: alu_res = opnd;
        endcase
    end

    // ------------------------------------------------------------
    // data path registers and status flags
    // ------------------------------------------------------------
    logic [7:0] w_addr, w_data, w_eff;
    logic w_en, w_drop, w_disp;

    always_comb begin
        w_en = DM_WR_I || (ALU_GO_I && alu_writes && !ALU_DEST_ACC_I);
        w_addr = DM_ADDR_I;
        w_data = DM_WR_I ? DM_WDATA_I : alu_res;
        w_eff = eff_addr(w_addr); // [RULE1]
        w_drop = is_ind(w_addr) && is_ind(w_eff); // [RULE2]
        w_disp = w_en && !w_drop && (w_addr == csi_pkg::ADDR_IND_B) &&
                 DISP_BANK_I; // [RULE3]
        ram_pointer_a_d = ram_pointer_a_q;
        ram_pointer_b_d = ram_pointer_b_q;
        acc_d = acc_q;
        st_d = st_q;
        ram_we = 1'b0;
        ram_wa = w_eff - csi_pkg::ADDR_RAM_LO;
        ram_wd = w_data;
        disp_we_d = w_disp;
        disp_wdata_d = w_disp ? w_data : disp_wdata_q;
        if (w_en && !w_drop && !w_disp) begin
            if (w_eff >= csi_pkg::ADDR_RAM_LO) begin
                ram_we = 1'b1; // [RULE23]
            end
            case (w_eff)
                csi_pkg::ADDR_PTR_A: ram_pointer_a_d = w_data;
                csi_pkg::ADDR_PTR_B: ram_pointer_b_d = w_data;
                csi_pkg::ADDR_ACC: acc_d = w_data; // [RULE4]
                csi_pkg::ADDR_FLAGS: begin
                    st_d[3:0] = w_data[3:0] & csi_pkg::ARITH_FLAG_MASK; // [RULE7]
                end
                default: ;
            endcase
        end
        if (ALU_GO_I) begin
            if (alu_writes && ALU_DEST_ACC_I) begin
                acc_d = alu_res;
            end
            if (is_arith) begin
                st_d.carry_flag = sum9[8]; // [RULE8]
                st_d.half_carry_flag = low5[4]; // [RULE9]
                st_d.signed_wrap_flag = (acc_q[7] ^ bb[7] ^ sum9[7]) ^
                                        sum9[8]; // [RULE11]
                st_d.zero_flag = (alu_res == 8'h00); // [RULE10]
            end
            if (is_logic) begin
                st_d.zero_flag = (alu_res == 8'h00); // [RULE10]
            end
            if (op == csi_pkg::OP_RLC) begin
                st_d.carry_flag = opnd[7]; // [RULE8]
            end
            if (op == csi_pkg::OP_RRC) begin
                st_d.carry_flag = opnd[0]; // [RULE8]
            end
            if (op == csi_pkg::OP_DAA) begin
                st_d.carry_flag = st_q.carry_flag ||
                    (acc_q[7:4] > csi_pkg::BCD_LIMIT);
            end
        end
        if (WDT_CLEAR_I) begin
            st_d.halt_entered_flag = 1'b0; // [RULE12]
            st_d.watchdog_expired_flag = 1'b0; // [RULE13]
        end
        if (HALT_EXEC_I) begin
            st_d.halt_entered_flag = 1'b1; // [RULE12]
            st_d.watchdog_expired_flag = 1'b0; // [RULE13]
        end
        if (WDT_TIMEOUT_I) begin
            st_d.watchdog_expired_flag = 1'b1; // [RULE13]
        end
        rdata_d = DM_RD_I ? rd_value(DM_ADDR_I) : rdata_q;
        skip_d = 1'b0;
        if (ALU_GO_I && is_skip) begin
            skip_d = (op == csi_pkg::OP_SNZ) ? (opnd != 8'h00)
                   : (op == csi_pkg::OP_SZ) ? (opnd == 8'h00)
                   : (alu_res == 8'h00); // [RULE5]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (ram_we) begin
            ram_q[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ram_pointer_a_q <= csi_pkg::RST_BYTE;
            ram_pointer_b_q <= csi_pkg::RST_BYTE;
            acc_q <= csi_pkg::RST_BYTE;
            st_q <= '0;
            rdata_q <= csi_pkg::RST_BYTE;
            skip_q <= 1'b0;
            disp_we_q <= 1'b0;
            disp_wdata_q <= csi_pkg::RST_BYTE;
        end else begin
            ram_pointer_a_q <= ram_pointer_a_d;
            ram_pointer_b_q <= ram_pointer_b_d;
            acc_q <= acc_d;
            st_q <= st_d;
            rdata_q <= rdata_d;
            skip_q <= skip_d;
            disp_we_q <= disp_we_d;
            disp_wdata_q <= disp_wdata_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt request, priority and acknowledge
    // ------------------------------------------------------------
    logic [5:0] set_evt, pend;
    logic ack;
    logic [2:0] pick;

    always_comb begin
        set_evt = {RTC_I, TBASE_I, TMR1_OVF_I, TMR0_OVF_I,
                   ext_b_sync_q[2] & ~ext_b_sync_q[1],
                   ext_a_sync_q[2] & ~ext_a_sync_q[1]}; // [RULE20] [RULE26]
        pend = irq_req_q & irq_en_q;
        pick = 3'd0;
        for (int i = csi_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 3'(i); // [RULE25] [RULE27]
            end
        end
        ack = BOUNDARY_I && global_irq_enable_q && (|pend) &&
              !STACK_FULL_I && !call_q; // [RULE19] [RULE18] [RULE24]
        irq_en_d = irq_en_q;
        irq_req_d = irq_req_q;
        global_irq_enable_d = global_irq_enable_q;
        if (w_en && !w_drop && !w_disp && w_eff == csi_pkg::ADDR_IRQ_CTRL_A) begin
            global_irq_enable_d = w_data[0]; // [RULE24]
            irq_en_d[2:0] = w_data[3:1];
            irq_req_d[2:0] = w_data[6:4];
        end
        if (w_en && !w_drop && !w_disp && w_eff == csi_pkg::ADDR_IRQ_CTRL_B) begin
            irq_en_d[5:3] = w_data[2:0];
            irq_req_d[5:3] = w_data[6:4];
        end
        if (ack) begin
            irq_req_d[pick] = 1'b0; // [RULE21]
            global_irq_enable_d = 1'b0; // [RULE17]
        end
        if (RETI_I) begin
            global_irq_enable_d = 1'b1;
        end
        irq_req_d = irq_req_d | set_evt; // [RULE26]
        call_d = ack; // [RULE16] [RULE15]
        vec_d = ack ? csi_pkg::VEC_BASE + 13'(pick) * csi_pkg::VEC_STEP
                    : vec_q; // [RULE21]
        halted_d = halted_q;
        if (HALT_EXEC_I) begin
            halted_d = 1'b1;
        end else if ((|irq_req_q) || WDT_TIMEOUT_I) begin
            halted_d = 1'b0; // [RULE22]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ext_a_sync_q <= 3'h7;
            ext_b_sync_q <= 3'h7;
            irq_en_q <= csi_pkg::RST_IRQ_BITS;
            irq_req_q <= csi_pkg::RST_IRQ_BITS;
            global_irq_enable_q <= 1'b0;
            call_q <= 1'b0;
            vec_q <= 13'h000;
            halted_q <= 1'b0;
        end else begin
            ext_a_sync_q <= {ext_a_sync_q[1:0], EXT_IRQ_A_N_I};
            ext_b_sync_q <= {ext_b_sync_q[1:0], EXT_IRQ_B_N_I};
            irq_en_q <= irq_en_d;
            irq_req_q <= irq_req_d;
            global_irq_enable_q <= global_irq_enable_d;
            call_q <= call_d;
            vec_q <= vec_d;
            halted_q <= halted_d;
        end
    end

    assign DM_RDATA_O = rdata_q;
    assign SKIP_O = skip_q;
    assign DISP_ADDR_O = ram_pointer_b_q;
    assign DISP_WDATA_O = disp_wdata_q;
    assign DISP_WE_O = disp_we_q;
    assign HALTED_O = halted_q;
    assign IRQ_CALL_O = call_q;
    assign IRQ_VECTOR_O = vec_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_fall_a;
        ext_a_sync_q[2] ##1 !ext_a_sync_q[2];
    endsequence
    property p_ind_self_zero;
        DM_RD_I && DM_ADDR_I == 8'h00 && ram_pointer_a_q == 8'h02
            |=> DM_RDATA_O == 8'h00;
    endproperty
    a_ind_self_zero: assert property (p_ind_self_zero) else $error("bad self read"); // [RULE2]
    property p_flags_hi_zero;
        DM_RD_I && DM_ADDR_I == 8'h0a |=> DM_RDATA_O[7:6] == 2'b00;
    endproperty
    a_flags_hi_zero: assert property (p_flags_hi_zero) else $error("status hi set"); // [RULE14]
    property p_sw_keeps_sys;
        DM_WR_I && DM_ADDR_I == 8'h0a && !HALT_EXEC_I && !WDT_CLEAR_I &&
        !WDT_TIMEOUT_I |=> $stable(st_q[5:4]);
    endproperty
    a_sw_keeps_sys: assert property (p_sw_keeps_sys) else $error("write hit pdf"); // [RULE7]
    property p_ack_clears;
        IRQ_CALL_O |-> !global_irq_enable_q || $past(RETI_I);
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("enable kept"); // [RULE17]
    property p_full_block;
        STACK_FULL_I |=> !IRQ_CALL_O;
    endproperty
    a_full_block: assert property (p_full_block) else $error("ack when full"); // [RULE19]
    property p_edge_a;
        s_fall_a |-> irq_req_q[0];
    endproperty
    a_edge_a: assert property (p_edge_a) else $error("edge a lost"); // [RULE20]
    property p_halt_flags;
        HALT_EXEC_I && !WDT_TIMEOUT_I |=> st_q[5:4] == 2'b01 && HALTED_O;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags"); // [RULE12]
    property p_timeout;
        WDT_TIMEOUT_I |=> st_q.watchdog_expired_flag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout lost"); // [RULE13]
    property p_ext_b_vec;
        BOUNDARY_I && global_irq_enable_q && pend[1:0] == 2'b10 &&
        !STACK_FULL_I && !call_q |=> IRQ_CALL_O && IRQ_VECTOR_O == 13'h008;
    endproperty
    a_ext_b_vec: assert property (p_ext_b_vec) else $error("vector b"); // [RULE21]
    property p_wake;
        HALTED_O && (|irq_req_q) && !HALT_EXEC_I |=> !HALTED_O;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake"); // [RULE22]

endmodule

// ---- include/csi_pkg.sv ----
package csi_pkg;

    // ------------------------------------------------------------
    // data map locations
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_IND_A = 8'h00;
    localparam logic [7:0] ADDR_PTR_A = 8'h01;
    localparam logic [7:0] ADDR_IND_B = 8'h02;
    localparam logic [7:0] ADDR_PTR_B = 8'h03;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_FLAGS = 8'h0a;
    localparam logic [7:0] ADDR_IRQ_CTRL_A = 8'h0b;
    localparam logic [7:0] ADDR_IRQ_CTRL_B = 8'h1e;
    localparam logic [7:0] ADDR_RAM_LO = 8'h20;
    localparam int RAM_DEPTH = 224;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_IRQ_BITS = 6'h00;
    localparam logic [3:0] ARITH_FLAG_MASK = 4'hf;
    localparam int NUM_SRC = 6;
    localparam logic [12:0] VEC_BASE = 13'h004;
    localparam logic [12:0] VEC_STEP = 13'h004;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [7:0] BCD_ADJ_LO = 8'h06;
    localparam logic [7:0] BCD_ADJ_HI = 8'h60;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA,
        OP_AND, OP_OR, OP_XOR, OP_CPL,
        OP_RL, OP_RR, OP_RLC, OP_RRC,
        OP_INC, OP_DEC,
        OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ
    } csi_alu_op_type;

    typedef struct packed {
        logic watchdog_expired_flag;
        logic halt_entered_flag;
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } csi_status_type;

endpackage

// ---- bench/csi_seq_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// sequencer and stack stand-in: boundary pulses, stack depth
// ----------------------------------------------------------------
module csi_seq_model #(
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic call_i,
    input wire logic ret_i,
    output logic boundary_o,
    output logic stack_full_o
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    int depth_q;
    int depth_d;
    always_comb begin
        phase_d = phase_q + 2'h1;
        depth_d = depth_q;
        if (call_i) begin
            depth_d = depth_d + 1;  // only the pc is pushed
        end
        if (ret_i && depth_q > 0) begin
            depth_d = depth_d - 1;  // return frees a level
        end
    end
    always_ff @(posedge clk_i) begin
        phase_q <= rst_i ? 2'h0 : phase_d;
        depth_q <= rst_i ? 0 : depth_d;
    end
    assign boundary_o = (phase_q == 2'h3);
    assign stack_full_o = (depth_q >= DEPTH);
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic go = 1'b0;
    logic [4:0] op = 5'h00;
    logic pin_a = 1'b1;
    logic pin_b = 1'b1;
    logic [7:0] pls = 8'h00;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [12:0] vec;
    logic halted;
    logic call;
    logic bnd;
    logic full;
    logic dbank = 1'b0;
    logic dest = 1'b1;
    logic skip;
    logic dwe;
    logic [7:0] daddr;
    logic [7:0] dwdata;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] rows [10][4] = '{
        '{8'h01, 8'h21, 8'h01, 8'h21}, '{8'h00, 8'h5a, 8'h21, 8'h5a},
        '{8'h03, 8'h22, 8'h03, 8'h22}, '{8'h02, 8'ha5, 8'h22, 8'ha5},
        '{8'h05, 8'h3c, 8'h05, 8'h3c}, '{8'h0a, 8'hff, 8'h0a, 8'h0f},
        '{8'h04, 8'hff, 8'h04, 8'h00}, '{8'h01, 8'h02, 8'h00, 8'h00},
        '{8'h00, 8'h77, 8'h22, 8'ha5}, '{8'hff, 8'h99, 8'hff, 8'h99}};
    initial begin
        forever #50 clk = ~clk;
    end
    csi_core dut (.CLK_SYS_I(clk), .RST_I(rst), .DM_ADDR_I(addr),
        .DM_RD_I(rd), .DM_WR_I(wr), .DM_WDATA_I(wdata), .DM_RDATA_O(rdata),
        .ALU_GO_I(go), .ALU_OP_I(op), .ALU_DEST_ACC_I(dest), .SKIP_O(skip),
        .DISP_BANK_I(dbank), .DISP_RDATA_I(~daddr), .DISP_ADDR_O(daddr),
        .DISP_WDATA_O(dwdata), .DISP_WE_O(dwe), .HALT_EXEC_I(pls[4]),
        .WDT_CLEAR_I(pls[5]), .WDT_TIMEOUT_I(pls[6]), .HALTED_O(halted),
        .EXT_IRQ_A_N_I(pin_a), .EXT_IRQ_B_N_I(pin_b), .TMR0_OVF_I(pls[0]),
        .TMR1_OVF_I(pls[1]), .TBASE_I(pls[2]), .RTC_I(pls[3]),
        .BOUNDARY_I(bnd), .STACK_FULL_I(full), .RETI_I(pls[7]),
        .IRQ_CALL_O(call), .IRQ_VECTOR_O(vec));
    csi_seq_model #(.DEPTH(2)) partner (.clk_i(clk), .rst_i(rst),
        .call_i(call), .ret_i(pls[7]), .boundary_o(bnd),
        .stack_full_o(full));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [12:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({5'h00, rdata}, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        pls <= 8'h01 << i;
        @(posedge clk);
        pls <= 8'h00;
    endtask
    task automatic alu(input logic [4:0] o, input logic [7:0] a, b, ea, ef);
        wr_reg(8'h05, a);
        wr_reg(8'h20, b);
        @(posedge clk);
        addr <= 8'h20;
        op <= o;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        rd_reg(8'h05, {5'h00, ea});
        rd_reg(8'h0a, {5'h00, ef});
    endtask
    task automatic wait_call(input logic [12:0] ev);
        int n;
        n = 0;
        #1;
        while (call !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({12'h000, call}, 13'h001);
        chk(vec, ev);
    endtask
    task automatic conclude();
        $display("%0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            wr_reg(rows[i][0], rows[i][1]);
            rd_reg(rows[i][2], {5'h00, rows[i][3]});
        end
        @(posedge clk);
        dbank <= 1'b1;
        wr_reg(8'h02, 8'h3c);
        #1;
        chk({4'h0, dwe, dwdata}, 13'h13c);
        chk({5'h00, daddr}, 13'h022);
        rd_reg(8'h02, 13'h0dd);
        @(posedge clk);
        dbank <= 1'b0;
        rd_reg(8'h22, 13'h0a5);
        $display("test map done");
        alu(csi_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 8'h0d);
        alu(csi_pkg::OP_ADD, 8'h0f, 8'h01, 8'h10, 8'h02);
        alu(csi_pkg::OP_RLC, 8'h00, 8'h81, 8'h02, 8'h03);
        alu(csi_pkg::OP_SUB, 8'h03, 8'h05, 8'hfe, 8'h00);
        wr_reg(8'h20, 8'hff);
        @(posedge clk);
        dest <= 1'b0;
        addr <= 8'h20;
        op <= csi_pkg::OP_SIZ;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        dest <= 1'b1;
        #1;
        chk({12'h000, skip}, 13'h001);
        rd_reg(8'h20, 13'h000);
        rd_reg(8'h05, 13'h0fe);
        $display("test alu done");
        wr_reg(8'h0b, 8'h0e);
        @(posedge clk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        pulse(0);
        repeat (6) @(posedge clk);
        rd_reg(8'h0b, 13'h07e);
        wr_reg(8'h0b, 8'h7f);
        wait_call(13'h004);
        rd_reg(8'h0b, 13'h06e);
        wr_reg(8'h0b, 8'h6f);
        wait_call(13'h008);
        wr_reg(8'h0b, 8'h4f);
        repeat (16) begin
            @(posedge clk);
            #1;
            chk({12'h000, call}, 13'h000);
        end
        pulse(7);
        wait_call(13'h00c);
        wr_reg(8'h1e, 8'h07);
        for (int i = 0; i < 3; i++) begin
            pulse(7);
            pulse(1 + i);
            wait_call(13'h010 + 13'(4 * i));
        end
        $display("test irq done");
        pulse(4);
        rd_reg(8'h0a, 13'h010);
        chk({12'h000, halted}, 13'h001);
        pulse(6);
        rd_reg(8'h0a, 13'h030);
        pulse(5);
        rd_reg(8'h0a, 13'h000);
        pulse(4);
        pulse(3);
        repeat (3) @(posedge clk);
        #1;
        chk({12'h000, halted}, 13'h000);
        $display("test halt done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({4'h0, halted, rdata}, 13'h000);
        rd_reg(8'h0a, 13'h000);
        $display("test reset done");
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
